/* File: bss_display_model.sv */
`timescale 1ns/100ps
// display side: sends query sentences and takes status characters
module bss_display_model (
	// clock
	input  wire logic       mclk_i,
	// sink side, stall_i holds off acceptance
	input  wire logic       stall_i,
	input  wire logic       tx_valid_i,
	input  wire logic [7:0] tx_data_i,
	output logic            tx_ready_o,
	// query characters towards the framer
	output logic            rx_valid_o,
	output logic [7:0]      rx_data_o
);
	logic [7:0] got[$];
	realtime    t_id[$];

	assign tx_ready_o = !stall_i;

	// collect characters; 'S' is never a hex digit, so it marks a start
	always @(posedge mclk_i) begin
		if (tx_valid_i && tx_ready_o) begin
			got.push_back(tx_data_i);
			if (tx_data_i == 8'h53) begin
				t_id.push_back($realtime);
			end
		end
	end

	initial begin
		rx_valid_o = 1'b0;
		rx_data_o  = 8'h00;
	end

	// one char per cycle; idle data is inverted so it is never stale
	task automatic send(input string s);
		for (int i = 0; i < s.len(); i++) begin
			@(negedge mclk_i);
			rx_valid_o = 1'b1;
			rx_data_o  = s[i];
		end
		@(negedge mclk_i);
		rx_valid_o = 1'b0;
		rx_data_o  = ~rx_data_o;
	endtask
endmodule

/* File: bss_pkg.sv */
package bss_pkg;

	// timing: one second of stage duration and period count
	localparam int CLK_HZ     = 250_000_000;
	localparam int SEC_S      = 1;
	localparam int SEC_CYCLES = SEC_S * CLK_HZ;

	// sentence characters
	localparam logic [7:0] ID_C0    = 8'h53;
	localparam logic [7:0] ID_C1    = 8'h54;
	localparam logic [7:0] ID_C2    = 8'h31;
	localparam logic [7:0] CH_COMMA = 8'h2c;
	localparam logic [7:0] CH_QUERY = 8'h3f;
	localparam logic [7:0] CH_CR    = 8'h0d;
	localparam logic [7:0] CH_LF    = 8'h0a;

	// field layout of the snapshot, most significant field sent first
	localparam int NFIELD  = 8;
	localparam int SNAP_W  = 128;
	localparam int F_STAGE = 120;
	localparam int F_ERR   = 112;
	localparam int F_PARAM = 96;
	localparam int F_DUR   = 64;
	localparam int F_BATT  = 56;
	localparam int F_PROT  = 40;
	localparam int F_PWR   = 32;

	// defined bits of the flag fields, reserved bits read zero
	localparam logic [7:0]  BATT_MASK = 8'h3f;
	localparam logic [15:0] PROT_MASK = 16'h3c7f;
	localparam logic [7:0]  PWR_MASK  = 8'h27;
	localparam logic [31:0] PIN_MASK  = 32'h07ffffbe;
	localparam int PIN_SPEED = 1;
	localparam int PIN_SOC   = 11;
	localparam int PIN_CUR0  = 14;

	// charging stage codes of the first field
	typedef enum logic [2:0] {
		BSS_DISCONN  = 3'h0,
		BSS_PREHEAT  = 3'h1,
		BSS_PRECHG   = 3'h2,
		BSS_MAINCHG  = 3'h3,
		BSS_BALANCE  = 3'h4,
		BSS_FINISHED = 3'h5,
		BSS_CHGERR   = 3'h6
	} bss_stage_e;

	// framer states, gray along the sentence path except the step from BSS_ID to BSS_SEP
	typedef enum logic [2:0] {
		BSS_IDLE = 3'b000,
		BSS_ID   = 3'b001,
		BSS_HEX  = 3'b011,
		BSS_SEP  = 3'b010,
		BSS_CSH  = 3'b110,
		BSS_CSL  = 3'b111,
		BSS_CR   = 3'b101,
		BSS_LF   = 3'b100
	} bss_state_e;

	// hex characters in each field, in sending order
	function automatic logic [3:0] fld_nibs(input logic [2:0] idx);
		case (idx)
			3'h2, 3'h5: fld_nibs = 4'h4;
			3'h3, 3'h7: fld_nibs = 4'h8;
			default:    fld_nibs = 4'h2;
		endcase
	endfunction

	// one nibble as an upper-case ascii hex character
	function automatic logic [7:0] hex_char(input logic [3:0] nib);
		if (nib < 4'ha) begin
			hex_char = 8'h30 + {4'h0, nib};
		end else begin
			hex_char = 8'h37 + {4'h0, nib};
		end
	endfunction

endpackage

/* File: bss_status_framer.sv */
`timescale 1ns/100ps
// How it works
// - sent periodically; separate active and sleep intervals in seconds
// - a query sentence with a single '?' field triggers one complete sentence
// - stage field codes 0 disconnected through 6 charging error
// - error field holds the most recent error code, 0 meaning none
// - error parameter holds the stage active just before the error
// - stage duration counts seconds since the present stage began
// - battery validity bits 0-3 and 5 pass, bits 6-7 read zero
// - battery bit 4 passes from batt_flags_i like bits 0-3 and 5
// - protection bits 0-6 report the cell and pack protection events
// - protection bits 10-13 pass; bits 7-9 and 14-15 read zero
// - power reduction bits 0,1,2,5 pass; all others read zero
// - pin bit 1 is set while speed is nonzero; bit 0 reads zero
// - pin bits 2-10 report pin states, bit 6 reads zero
// - pin bit 11 is set while state of charge is nonzero
// - pin bit 14 is set while current channel 0 reads nonzero
// - pin bits 12-13 and 15-26 report pin states, bits 27-31 read zero
module bss_status_framer #(
	parameter int SEC_CYCLES = bss_pkg::SEC_CYCLES
) (
	// clock and reset
	input  wire logic        mclk_i,
	input  wire logic        nrst_i,
	// period settings, in seconds, zero stops periodic sending
	input  wire logic        sleep_i,
	input  wire logic [15:0] act_period_i,
	input  wire logic [15:0] slp_period_i,
	// charging state
	input  wire logic [2:0]  stage_i,
	input  wire logic        err_valid_i,
	input  wire logic [3:0]  err_code_i,
	// flag sources
	input  wire logic [7:0]  batt_flags_i,
	input  wire logic [15:0] prot_flags_i,
	input  wire logic [7:0]  pwr_flags_i,
	input  wire logic [31:0] pin_state_i,
	input  wire logic [31:0] pin_mapped_i,
	input  wire logic [15:0] speed_i,
	input  wire logic [7:0]  soc_i,
	input  wire logic [15:0] cur0_i,
	// received characters
	input  wire logic        rx_valid_i,
	input  wire logic [7:0]  rx_data_i,
	// transmitted characters
	input  wire logic        tx_ready_i,
	output logic             tx_valid_o,
	output logic [7:0]       tx_data_o,
	output logic             busy_o
);

	if (SEC_CYCLES < 2) begin : g_bad_sec
		$error("SEC_CYCLES must be at least 2");
	end

	bss_pkg::bss_state_e state;
	logic [31:0] div_cnt;
	logic        tick;
	logic [15:0] per_cnt;
	logic        per_pend;
	logic        qry_pend;
	logic [2:0]  rx_idx;
	logic [2:0]  stage_q;
	logic [31:0] dur;
	logic [7:0]  last_err;
	logic [15:0] err_param;
	logic [bss_pkg::SNAP_W-1:0] snap;
	logic [1:0]  id_idx;
	logic [3:0]  nib;
	logic [3:0]  fld;
	logic [7:0]  csum;
	logic        slot;
	logic        start;
	logic        qry_hit;
	logic        per_hit;
	logic [15:0] period;
	logic [31:0] pins;
	logic [7:0]  next_char;

	// output slot free when nothing waits or the waiting char is taken
	assign slot    = !tx_valid_o || tx_ready_i;
	assign start   = (state == bss_pkg::BSS_IDLE) && (per_pend || qry_pend)
		&& slot;
	assign period  = sleep_i ? slp_period_i : act_period_i;
	assign per_hit = tick && (period != 16'h0000)
		&& (per_cnt + 16'h0001 >= period);
	assign qry_hit = rx_valid_i && (rx_idx == 3'h5)
		&& ((rx_data_i == bss_pkg::CH_CR) || (rx_data_i == bss_pkg::CH_LF));

	// pin flags: unmapped functions read zero, derived bits from measures
	always_comb begin
		pins = pin_state_i & pin_mapped_i & bss_pkg::PIN_MASK;
		pins[bss_pkg::PIN_SPEED] = pin_mapped_i[bss_pkg::PIN_SPEED]
			&& (speed_i != 16'h0000);
		pins[bss_pkg::PIN_SOC] = pin_mapped_i[bss_pkg::PIN_SOC]
			&& (soc_i != 8'h00);
		pins[bss_pkg::PIN_CUR0] = pin_mapped_i[bss_pkg::PIN_CUR0]
			&& (cur0_i != 16'h0000);
	end

	// one-second enable pulse
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			div_cnt <= 32'h0;
			tick    <= 1'b0;
		end else if (div_cnt == 32'(SEC_CYCLES - 1)) begin
			div_cnt <= 32'h0;
			tick    <= 1'b1;
		end else begin
			div_cnt <= div_cnt + 32'h1;
			tick    <= 1'b0;
		end
	end

	// interval counter; a shorter new period takes effect at the next tick
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			per_cnt <= 16'h0;
		end else if (per_hit) begin
			per_cnt <= 16'h0;
		end else if (tick) begin
			per_cnt <= per_cnt + 16'h1;
		end
	end

	// pending requests; a new event wins over the clear by start
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			per_pend <= 1'b0;
			qry_pend <= 1'b0;
		end else begin
			per_pend <= (per_pend && !start) || per_hit;
			qry_pend <= (qry_pend && !start) || qry_hit;
		end
	end

	// query matcher: identifier, comma, '?', then CR or LF
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			rx_idx <= 3'h0;
		end else if (rx_valid_i) begin
			case (rx_idx)
				3'h0: rx_idx <= (rx_data_i == bss_pkg::ID_C0) ? 3'h1 : 3'h0;
				3'h1: rx_idx <= (rx_data_i == bss_pkg::ID_C1) ? 3'h2 : 3'h0;
				3'h2: rx_idx <= (rx_data_i == bss_pkg::ID_C2) ? 3'h3 : 3'h0;
				3'h3: rx_idx <= (rx_data_i == bss_pkg::CH_COMMA) ? 3'h4 : 3'h0;
				3'h4: rx_idx <= (rx_data_i == bss_pkg::CH_QUERY) ? 3'h5 : 3'h0;
				default: rx_idx <= 3'h0;
			endcase
		end
	end

	// stage duration in seconds, restarted on every stage change
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			stage_q <= 3'h0;
			dur     <= 32'h0;
		end else begin
			stage_q <= stage_i;
			if (stage_i != stage_q) begin
				dur <= 32'h0;
			end else if (tick && (dur != 32'hffffffff)) begin
				dur <= dur + 32'h1;
			end
		end
	end

	// last error and the stage that was running when it came
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			last_err  <= 8'h0;
			err_param <= 16'h0;
		end else if (err_valid_i) begin
			last_err  <= {4'h0, err_code_i};
			err_param <= {13'h0, stage_q};
		end
	end

	// character chosen for the present state
	always_comb begin
		case (state)
			bss_pkg::BSS_IDLE: next_char = bss_pkg::ID_C0;
			bss_pkg::BSS_ID:
				next_char = (id_idx == 2'h1) ? bss_pkg::ID_C1
					: bss_pkg::ID_C2;
			bss_pkg::BSS_HEX: next_char = bss_pkg::hex_char(snap[127:124]);
			bss_pkg::BSS_SEP: next_char = bss_pkg::CH_COMMA;
			bss_pkg::BSS_CSH: next_char = bss_pkg::hex_char(csum[7:4]);
			bss_pkg::BSS_CSL: next_char = bss_pkg::hex_char(csum[3:0]);
			bss_pkg::BSS_CR:  next_char = bss_pkg::CH_CR;
			default:          next_char = bss_pkg::CH_LF;
		endcase
	end

	// sentence sequencer, one character per free output slot
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			state  <= bss_pkg::BSS_IDLE;
			id_idx <= 2'h0;
			nib    <= 4'h0;
			fld    <= 4'h0;
		end else if (slot) begin
			case (state)
				bss_pkg::BSS_IDLE: begin
					if (start) begin
						state  <= bss_pkg::BSS_ID;
						id_idx <= 2'h1;
						nib    <= 4'h0;
						fld    <= 4'h0;
					end
				end
				bss_pkg::BSS_ID: begin
					id_idx <= id_idx + 2'h1;
					if (id_idx == 2'h2) begin
						state <= bss_pkg::BSS_SEP;
					end
				end
				bss_pkg::BSS_SEP: begin
					state <= (fld == 4'(bss_pkg::NFIELD)) ? bss_pkg::BSS_CSH
						: bss_pkg::BSS_HEX;
				end
				bss_pkg::BSS_HEX: begin
					if (nib == bss_pkg::fld_nibs(fld[2:0]) - 4'h1) begin
						nib   <= 4'h0;
						fld   <= fld + 4'h1;
						state <= bss_pkg::BSS_SEP;
					end else begin
						nib <= nib + 4'h1;
					end
				end
				bss_pkg::BSS_CSH: state <= bss_pkg::BSS_CSL;
				bss_pkg::BSS_CSL: state <= bss_pkg::BSS_CR;
				bss_pkg::BSS_CR:  state <= bss_pkg::BSS_LF;
				default:          state <= bss_pkg::BSS_IDLE;
			endcase
		end
	end

	// snapshot at start so the fields of one sentence are coherent
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			snap <= '0;
		end else if (start) begin
			snap <= {5'h0, stage_i,
				last_err, err_param, dur,
				batt_flags_i & bss_pkg::BATT_MASK,
				prot_flags_i & bss_pkg::PROT_MASK,
				pwr_flags_i & bss_pkg::PWR_MASK,
				pins};
		end else if (slot && (state == bss_pkg::BSS_HEX)) begin
			snap <= {snap[123:0], 4'h0};
		end
	end

	// checksum: byte sum of everything up to and including the last comma
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			csum <= 8'h0;
		end else if (start) begin
			csum <= bss_pkg::ID_C0;
		end else if (slot && ((state == bss_pkg::BSS_ID)
			|| (state == bss_pkg::BSS_SEP) || (state == bss_pkg::BSS_HEX))) begin
			csum <= csum + next_char;
		end
	end

	// output register; holds its char until the sink takes it
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			tx_valid_o <= 1'b0;
			tx_data_o  <= 8'h0;
			busy_o     <= 1'b0;
		end else begin
			busy_o <= (state != bss_pkg::BSS_IDLE) || start;
			if (slot) begin
				tx_valid_o <= (state != bss_pkg::BSS_IDLE) || start;
				tx_data_o  <= next_char;
			end
		end
	end

	chk_frame_start: assert property (@(posedge mclk_i)
		disable iff (!nrst_i) start |=> tx_valid_o && (tx_data_o == bss_pkg::ID_C0))
		else $error("sentence did not open with the identifier");
	chk_query_pend: assert property (@(posedge mclk_i)
		disable iff (!nrst_i) qry_hit |=> qry_pend || busy_o)
		else $error("query was not taken");
	chk_period_pend: assert property (@(posedge mclk_i)
		disable iff (!nrst_i) per_hit |=> per_pend || busy_o)
		else $error("period expiry was lost");
	chk_stage_code: assert property (@(posedge mclk_i)
		disable iff (!nrst_i) start |=> snap[127:120] == {5'h0, $past(stage_i)})
		else $error("stage field wrong");
	chk_err_param: assert property (@(posedge mclk_i)
		disable iff (!nrst_i) err_valid_i |=> (err_param ==
			{13'h0, $past(stage_q)}) && (last_err == {4'h0, $past(err_code_i)}))
		else $error("error capture wrong");
	chk_dur_clear: assert property (@(posedge mclk_i)
		disable iff (!nrst_i) (stage_i != stage_q) |=> dur == 32'h0)
		else $error("duration not restarted");
	chk_batt_flags: assert property (@(posedge mclk_i)
		disable iff (!nrst_i) start |=>
			snap[63:56] == ($past(batt_flags_i) & bss_pkg::BATT_MASK))
		else $error("battery flags wrong");
	chk_prot_flags: assert property (@(posedge mclk_i)
		disable iff (!nrst_i) start |=>
			snap[55:40] == ($past(prot_flags_i) & bss_pkg::PROT_MASK))
		else $error("protection flags wrong");
	chk_pwr_flags: assert property (@(posedge mclk_i)
		disable iff (!nrst_i) start |=>
			snap[39:32] == ($past(pwr_flags_i) & bss_pkg::PWR_MASK))
		else $error("power reduction flags wrong");
	chk_pin_speed: assert property (@(posedge mclk_i)
		disable iff (!nrst_i) start |=>
			snap[1] == ($past(pin_mapped_i[1]) && ($past(speed_i) != 16'h0)))
		else $error("speed flag wrong");
	chk_pin_soc: assert property (@(posedge mclk_i)
		disable iff (!nrst_i) start |=>
			snap[11] == ($past(pin_mapped_i[11]) && ($past(soc_i) != 8'h0)))
		else $error("charge level flag wrong");
	chk_pin_cur: assert property (@(posedge mclk_i)
		disable iff (!nrst_i) start |=>
			snap[14] == ($past(pin_mapped_i[14]) && ($past(cur0_i) != 16'h0)))
		else $error("current flag wrong");
	chk_end_line: assert property (@(posedge mclk_i)
		disable iff (!nrst_i) (state == bss_pkg::BSS_CR) && slot |=>
			tx_data_o == bss_pkg::CH_CR)
		else $error("line terminator missing");

	cov_query: cover property (@(posedge mclk_i) qry_hit ##[1:4] start);
	cov_periodic: cover property (@(posedge mclk_i) per_hit && !sleep_i);
	cov_sleep: cover property (@(posedge mclk_i) per_hit && sleep_i);
	cov_stall: cover property (@(posedge mclk_i)
		tx_valid_o && !tx_ready_i && busy_o);

endmodule

/* File: testbench.sv */
`timescale 1ns/100ps
module testbench;
	localparam int SEC = 200;
	// design inputs
	logic        mclk_i = 1'b0;
	logic        nrst_i = 1'b0;
	logic        sleep_i = 1'b0;
	logic [15:0] act_period_i = 16'h0000;
	logic [15:0] slp_period_i = 16'h0000;
	logic [2:0]  stage_i = 3'h0;
	logic        err_valid_i = 1'b0;
	logic [3:0]  err_code_i = 4'h0;
	logic [7:0]  batt_flags_i = 8'h00;
	logic [15:0] prot_flags_i = 16'h0000;
	logic [7:0]  pwr_flags_i = 8'h00;
	logic [31:0] pin_state_i = 32'h00000000;
	logic [31:0] pin_mapped_i = 32'h00000000;
	logic [15:0] speed_i = 16'h0000;
	logic [7:0]  soc_i = 8'h00;
	logic [15:0] cur0_i = 16'h0000;
	// link and model state
	logic        rx_valid, tx_ready, tx_valid, busy, stall, slow;
	logic [7:0]  rx_data, tx_data, m_sum;
	logic [31:0] st_r;
	// identifier head shared by the answered and the refused query
	string       id_s = "ST";
	logic [15:0] seed = 16'h8435;
	logic [3:0]  m_err = 4'h0;
	logic [2:0]  m_par = 3'h0;
	logic [7:0]  exp_q[$];
	int          err_total, n_checks, cyc, t_stage;

	always #2 mclk_i = ~mclk_i;
	always @(posedge mclk_i) cyc <= cyc + 1;
	// random stalls from the far side only while slow is set
	// the generator steps every cycle so a stall never freezes the link
	always @(negedge mclk_i) begin
		st_r = rnd();
		stall = slow & st_r[0];
	end

	bss_status_framer #(.SEC_CYCLES(SEC)) dut (.mclk_i(mclk_i),
		.nrst_i(nrst_i), .sleep_i(sleep_i), .act_period_i(act_period_i),
		.slp_period_i(slp_period_i), .stage_i(stage_i),
		.err_valid_i(err_valid_i), .err_code_i(err_code_i),
		.batt_flags_i(batt_flags_i), .prot_flags_i(prot_flags_i),
		.pwr_flags_i(pwr_flags_i), .pin_state_i(pin_state_i),
		.pin_mapped_i(pin_mapped_i), .speed_i(speed_i), .soc_i(soc_i),
		.cur0_i(cur0_i), .rx_valid_i(rx_valid), .rx_data_i(rx_data),
		.tx_ready_i(tx_ready), .tx_valid_o(tx_valid), .tx_data_o(tx_data),
		.busy_o(busy));
	bss_display_model disp (.mclk_i(mclk_i), .stall_i(stall),
		.tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready),
		.rx_valid_o(rx_valid), .rx_data_o(rx_data));

	function logic [31:0] rnd();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		rnd[31:16] = seed;
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		rnd[15:0] = seed;
	endfunction

	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// append a field as upper-case hex, most significant nibble first
	task automatic put(input logic [31:0] v, input int n, input bit c);
		logic [3:0] d;
		for (int i = n - 1; i >= 0; i--) begin
			d = v[i*4 +: 4];
			exp_q.push_back(d < 4'ha ? 8'h30 + d : 8'h37 + d);
		end
		if (c) exp_q.push_back(8'h2c);
	endtask

	// phase 50 of the second keeps duration edges far from any tick
	task automatic align();
		do @(negedge mclk_i); while (cyc % SEC != 50);
	endtask

	task automatic set_stage(input logic [2:0] s);
		align();
		stage_i = s;
		t_stage = cyc;
	endtask

	// randomise the flags, query, and compare the whole sentence
	task automatic query();
		logic [31:0] r, pins;
		align();
		r = rnd();
		batt_flags_i = r[7:0];
		prot_flags_i = r[23:8];
		pwr_flags_i = r[31:24];
		pin_state_i = rnd();
		pin_mapped_i = rnd();
		r = rnd();
		speed_i = r[0] ? r[31:16] : 16'h0000;
		soc_i = r[1] ? r[15:8] : 8'h00;
		cur0_i = r[2] ? r[23:8] : 16'h0000;
		pins = pin_state_i & pin_mapped_i & 32'h07ffffbe;
		pins[1] = pin_mapped_i[1] & (speed_i != 16'h0000);
		pins[11] = pin_mapped_i[11] & (soc_i != 8'h00);
		pins[14] = pin_mapped_i[14] & (cur0_i != 16'h0000);
		exp_q = {8'h53, 8'h54, 8'h31, 8'h2c};
		put(stage_i, 2, 1);
		put(m_err, 2, 1);
		put(m_par, 4, 1);
		put((cyc - t_stage) / SEC, 8, 1);
		put(batt_flags_i & 8'h3f, 2, 1);
		put(prot_flags_i & 16'h3c7f, 4, 1);
		put(pwr_flags_i & 8'h27, 2, 1);
		put(pins, 8, 1);
		m_sum = 8'h00;
		foreach (exp_q[i]) m_sum += exp_q[i];
		put(m_sum, 2, 0);
		exp_q.push_back(8'h0d);
		exp_q.push_back(8'h0a);
		disp.send({id_s, "1,?\015"});
		@(negedge mclk_i);
		chk("busy", busy, 1);
		for (int w = 0; w < 400 && disp.got.size() < 48; w++)
			@(negedge mclk_i);
		chk("idle", busy, 0);
		chk("count", disp.got.size(), 48);
		for (int i = 0; i < 48; i++)
			chk("char", i < disp.got.size() ? disp.got[i] : 'x, exp_q[i]);
		disp.got.delete();
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// the whole sequence needs about 7500 cycles
	initial begin
		#200us;
		err_total++;
		$display("watchdog expired");
		close_out();
	end

	initial begin
		slow = 1'b1;
		repeat (4) @(negedge mclk_i);
		nrst_i = 1'b1;
		// every stage and error codes 1 to 10, far side stalling
		for (int c = 1; c <= 10; c++) begin
			set_stage(3'(c % 7));
			@(negedge mclk_i);
			err_valid_i = 1'b1;
			err_code_i = 4'(c);
			m_err = 4'(c);
			m_par = stage_i;
			@(negedge mclk_i);
			err_valid_i = 1'b0;
			err_code_i = ~err_code_i;
			query();
		end
		$display("error and stage test done");
		set_stage(3'h5);
		repeat (650) @(negedge mclk_i);
		query();
		$display("duration test done");
		// a wrong identifier must not be answered
		disp.send({id_s, "2,?\015"});
		repeat (100) @(negedge mclk_i);
		chk("unanswered", disp.got.size(), 0);
		query();
		$display("refusal test done");
		slow = 1'b0;
		disp.t_id.delete();
		act_period_i = 16'h0002;
		repeat (1300) @(negedge mclk_i);
		chk("active gap", $rtoi((disp.t_id[$] - disp.t_id[$-1]) / 4.0),
			SEC * 2);
		disp.t_id.delete();
		sleep_i = 1'b1;
		slp_period_i = 16'h0001;
		repeat (700) @(negedge mclk_i);
		chk("sleep gap", $rtoi((disp.t_id[$] - disp.t_id[$-1]) / 4.0),
			SEC);
		$display("periodic test done");
		close_out();
	end
endmodule
